// >>> hdl/ccfl_flag_logic.sv
// Charge counter, unit flag latch, release filter and init sequencing
`timescale 1ns/1ns
module ccfl_flag_logic
  import ccfl_pkg::*;
#(
  parameter int CNT_W       = CCFL_CNT_W,
  parameter int INIT_CYC    = CCFL_INIT_CYC,
  parameter int SETTLE_CYC  = CCFL_SETTLE_CYC,
  parameter int RELEASE_CYC = CCFL_RELEASE_CYC,
  parameter int SELF_CYC    = CCFL_SELF_LOW_CYC
)(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic power_down_n,
  input  wire logic supply_ok,
  input  wire logic ramp_reverse_switch_a,
  input  wire logic ramp_reverse_switch_b,
  input  wire logic ramp_rising,
  input  wire logic flag_release_n,
  output logic      charge_unit_flag_n_o,
  output logic      charge_unit_flag_n_oe,
  output logic      charge_direction_o,
  output logic      charge_direction_oe,
  output logic      low_power,
  output logic      counts_settled
);
  localparam int TW = $clog2(SETTLE_CYC + 1);

  initial begin
    if (CNT_W < 2 || INIT_CYC < 1 || SETTLE_CYC < 1 ||
        RELEASE_CYC < SELF_CYC || SELF_CYC < 1 ||
        INIT_CYC > SETTLE_CYC || RELEASE_CYC > SETTLE_CYC)
      $error("ccfl_flag_logic: unsupported parameters");
  end

  ccfl_step_if stp ();

  logic [2:0]      ctl_meta_reg;
  logic [2:0]      ctl_sync_reg;
  logic            hold_rst;
  logic            run;
  ccfl_state_t     state_reg;
  logic [TW-1:0]   timer_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic            wrap;
  logic            flag_reg;
  logic            dir_reg;
  logic            live_pol_reg;
  logic [TW-1:0]   rel_cnt_reg;
  logic [TW-1:0]   self_cnt_reg;
  logic            release_hit;

  function automatic logic [CNT_W-1:0] step_count(
    input logic [CNT_W-1:0] c, input logic up);
    step_count = up ? c + 1'b1 : c - 1'b1;
  endfunction : step_count

  function automatic logic is_wrap(
    input logic [CNT_W-1:0] c, input logic up);
    is_wrap = up ? (&c) : (c == '0);
  endfunction : is_wrap

  // Pins arrive asynchronously, so all pass two flip-flops; they reset to
  // the idle high level so no false power-down follows a reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_meta_reg <= '1;
      ctl_sync_reg <= '1;
    end else begin
      ctl_meta_reg <= {power_down_n, supply_ok, flag_release_n};
      ctl_sync_reg <= ctl_meta_reg;
    end
  end

  // Power-down or undervoltage acts like a full reset of the state
  assign hold_rst = ~ctl_sync_reg[2] | ~ctl_sync_reg[1];
  assign run      = (state_reg == CCFL_RUN) && !hold_rst;

  ccfl_ramp_decode u_decode (
    .sys_clk               (sys_clk),
    .nrst                  (nrst),
    .run                   (run),
    .ramp_reverse_switch_a (ramp_reverse_switch_a),
    .ramp_reverse_switch_b (ramp_reverse_switch_b),
    .ramp_rising           (ramp_rising),
    .stp                   (stp.src)
  );

  // Init interval sequencing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= CCFL_INIT;
      timer_reg <= '0;
    end else if (hold_rst) begin
      state_reg <= CCFL_OFF;
      timer_reg <= '0;
    end else begin
      case (state_reg)
        CCFL_OFF: begin
          state_reg <= CCFL_INIT;
          timer_reg <= '0;
        end
        CCFL_INIT: begin
          if (timer_reg == TW'(INIT_CYC - 1)) begin
            state_reg <= CCFL_RUN;
            timer_reg <= '0;
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        CCFL_RUN: begin
          if (timer_reg != TW'(SETTLE_CYC))
            timer_reg <= timer_reg + 1'b1;
        end
        default: begin
          state_reg <= CCFL_OFF;
          timer_reg <= '0;
        end
      endcase
    end
  end

  assign count_next = step_count(count_reg, stp.up);
  assign wrap       = stp.step && is_wrap(count_reg, stp.up);

  // Counter ignores the flag and the release input entirely
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      count_reg <= '0;
    else if (hold_rst || !run)
      count_reg <= '0;
    else if (stp.step)
      count_reg <= count_next;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      live_pol_reg <= 1'b0;
    else if (hold_rst)
      live_pol_reg <= 1'b0;
    else if (stp.step)
      live_pol_reg <= stp.up;
  end

  // Release low-width filter; tied-back flag needs the shorter self width
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt_reg  <= '0;
      self_cnt_reg <= '0;
    end else begin
      if (ctl_sync_reg[0] || hold_rst)
        rel_cnt_reg <= '0;
      else if (rel_cnt_reg != TW'(RELEASE_CYC))
        rel_cnt_reg <= rel_cnt_reg + 1'b1;
      if (!flag_reg)
        self_cnt_reg <= '0;
      else if (self_cnt_reg != TW'(SELF_CYC))
        self_cnt_reg <= self_cnt_reg + 1'b1;
    end
  end

  // Tied pin: release low for the self width after the flag has been low that
  // long; a controller must honour the longer release width
  assign release_hit = (rel_cnt_reg == TW'(RELEASE_CYC)) ||
                       (rel_cnt_reg >= TW'(SELF_CYC) &&
                        self_cnt_reg == TW'(SELF_CYC));

  // A wrap in the release cycle holds off the release, but that wrap is not latched
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
      dir_reg  <= 1'b0;
    end else if (hold_rst) begin
      flag_reg <= 1'b0;
      dir_reg  <= 1'b0;
    end else if (wrap && !flag_reg) begin
      flag_reg <= 1'b1;
      dir_reg  <= stp.up;
    end else if (flag_reg && release_hit && !wrap) begin
      flag_reg <= 1'b0;
    end
    // A wrap while latched is dropped
  end

  // Open-drain pins: output value is always low, enable pulls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      charge_unit_flag_n_o  <= 1'b0;
      charge_unit_flag_n_oe <= 1'b0;
      charge_direction_o    <= 1'b0;
      charge_direction_oe   <= 1'b0;
      low_power             <= 1'b0;
      counts_settled        <= 1'b0;
    end else begin
      charge_unit_flag_n_o  <= 1'b0;
      charge_direction_o    <= 1'b0;
      charge_unit_flag_n_oe <= !hold_rst && flag_reg;
      charge_direction_oe   <= !hold_rst &&
                               (flag_reg ? !dir_reg : !live_pol_reg);
      low_power             <= !ctl_sync_reg[2];
      counts_settled        <= run && (timer_reg == TW'(SETTLE_CYC));
    end
  end

  sequence s_flag_rise;
    !flag_reg ##1 flag_reg;
  endsequence

  a_flag_on_wrap : assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrap && !flag_reg && !hold_rst) |=> flag_reg)
    else $error("flag not latched on wrap");
  a_flag_only_wrap : assert property (@(posedge sys_clk) disable iff (!nrst)
    s_flag_rise |-> $past(wrap))
    else $error("flag set without wrap");
  a_dir_frozen : assert property (@(posedge sys_clk) disable iff (!nrst)
    (flag_reg && $past(flag_reg) && !hold_rst) |-> $stable(dir_reg))
    else $error("direction changed while latched");
  a_release_cause : assert property (@(posedge sys_clk) disable iff (!nrst)
    ($fell(flag_reg) && !$past(hold_rst)) |-> $past(release_hit))
    else $error("flag cleared without release");
  a_short_pulse : assert property (@(posedge sys_clk) disable iff (!nrst)
    ($fell(flag_reg) && !$past(hold_rst)) |-> $past(!ctl_sync_reg[0], 2))
    else $error("short release accepted");
  a_count_steady : assert property (@(posedge sys_clk) disable iff (!nrst)
    (run && !stp.step && $past(run)) |=> $stable(count_reg))
    else $error("counter moved without step");
  a_pd_release : assert property (@(posedge sys_clk) disable iff (!nrst)
    hold_rst |=> !charge_unit_flag_n_oe && !charge_direction_oe)
    else $error("outputs driven in power-down");
  a_pd_count : assert property (@(posedge sys_clk) disable iff (!nrst)
    hold_rst |=> (count_reg == '0) && !flag_reg)
    else $error("state survived reset");
  a_init_wait : assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == CCFL_OFF && !hold_rst) |=> state_reg == CCFL_INIT)
    else $error("init skipped after power-down");
endmodule : ccfl_flag_logic

// >>> hdl/ccfl_pkg.sv
// Constants and types for the charge count flag logic
package ccfl_pkg;
  localparam int CCFL_CLK_MHZ      = 100;
  localparam int CCFL_CNT_SPAN     = 1024;
  localparam int CCFL_CNT_W        = 10;
  localparam int CCFL_INTERVAL_US  = 600;
  localparam int CCFL_RELEASE_US   = 20;
  localparam int CCFL_SELF_LOW_US  = 1;
  localparam int CCFL_INIT_US      = 5000;
  localparam int CCFL_SETTLE_US    = 80000;
  localparam int CCFL_RELEASE_CYC  = CCFL_RELEASE_US * CCFL_CLK_MHZ;
  localparam int CCFL_SELF_LOW_CYC = CCFL_SELF_LOW_US * CCFL_CLK_MHZ;
  localparam int CCFL_INIT_CYC     = CCFL_INIT_US * CCFL_CLK_MHZ;
  localparam int CCFL_SETTLE_CYC   = CCFL_SETTLE_US * CCFL_CLK_MHZ;
  localparam int CCFL_INTERVAL_CYC = CCFL_INTERVAL_US * CCFL_CLK_MHZ;
  typedef enum logic [1:0] {CCFL_OFF, CCFL_INIT, CCFL_RUN} ccfl_state_t;
endpackage : ccfl_pkg

// >>> hdl/ccfl_step_if.sv
// Counter step events passed from the ramp decoder to the flag logic
`timescale 1ns/1ns
interface ccfl_step_if;
  logic step;
  logic up;
  modport src (output step, output up);
  modport dst (input step, input up);
endinterface : ccfl_step_if

// >>> hdl/ccfl_ramp_decode.sv
// Ramp reversal detector and polarity decoder
`timescale 1ns/1ns
module ccfl_ramp_decode
  import ccfl_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  input  wire logic   run,
  input  wire logic   ramp_reverse_switch_a,
  input  wire logic   ramp_reverse_switch_b,
  input  wire logic   ramp_rising,
  ccfl_step_if.src    stp
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic       dir_last_reg;
  logic       polarity;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      meta_reg <= {ramp_reverse_switch_a, ramp_reverse_switch_b, ramp_rising};
      sync_reg <= meta_reg;
    end
  end

  // Charging when switch a is closed and the ramp falls, or b closed and rising
  assign polarity = (sync_reg[2] & ~sync_reg[0]) |
                    (sync_reg[1] & sync_reg[0]);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dir_last_reg <= 1'b0;
      stp.step     <= 1'b0;
      stp.up       <= 1'b0;
    end else begin
      dir_last_reg <= sync_reg[0];
      stp.step     <= run && (dir_last_reg != sync_reg[0]);
      stp.up       <= polarity;
    end
  end
endmodule : ccfl_ramp_decode

// >>> testbench/ccfl_mcu_model.sv
// Controller model that services charge unit flags
`timescale 1ns/1ns
module ccfl_mcu_model #(
  parameter int HOLD = 14
)(
  input  wire logic sys_clk,
  input  wire logic enable,
  input  wire logic flag_pin_n,
  input  wire logic dir_pin,
  output logic      release_n,
  output logic      dir_seen
);
  initial begin
    release_n = 1'b1;
    dir_seen  = 1'b0;
    forever begin
      @(negedge sys_clk);
      if (enable && !flag_pin_n) begin
        dir_seen  = dir_pin;
        release_n = 1'b0;
        repeat (HOLD) @(negedge sys_clk);
        release_n = 1'b1;
        @(negedge sys_clk);
      end
    end
  end
endmodule : ccfl_mcu_model

// >>> testbench/tb_charge_count_flag_logic.sv
// Self-checking bench for the charge count flag logic
`timescale 1ns/1ns
module tb_charge_count_flag_logic;
  import ccfl_pkg::*;
  localparam int INIT = 20;
  localparam int REL  = 8;
  localparam int SELF = 2;
  typedef struct {
    int   n;
    logic up;
    logic mix;
    logic flag;
    logic dir;
  } ccfl_row_t;
  ccfl_row_t rows [7] = '{'{1, 1'b0, 1'b0, 1'b1, 1'b1},
    '{1, 1'b1, 1'b0, 1'b1, 1'b0}, '{1023, 1'b1, 1'b0, 1'b0, 1'b0},
    '{1, 1'b1, 1'b0, 1'b1, 1'b0}, '{1, 1'b0, 1'b0, 1'b1, 1'b1},
    '{1, 1'b1, 1'b1, 1'b1, 1'b0}, '{1, 1'b0, 1'b1, 1'b1, 1'b1}};
  logic sys_clk = 1'b0;
  logic nrst, pd_n, sup_ok, sw_a, sw_b, rising, tb_rel_n, tied, mcu_en;
  logic mix;
  logic flag_o, flag_oe, dir_o, dir_oe, low_power, settled;
  logic mcu_rel_n, dir_seen;
  logic flag_pin_n, dir_pin, rel_n;
  int   err_count = 0;
  int   n_tests   = 0;
  always #5 sys_clk = ~sys_clk;
  // Open-drain pins with pull-ups: a released pin reads high
  assign flag_pin_n = flag_oe ? flag_o : 1'b1;
  assign dir_pin    = dir_oe ? dir_o : 1'b1;
  assign rel_n      = tied ? flag_pin_n : (mcu_rel_n & tb_rel_n);
  ccfl_flag_logic #(.INIT_CYC(INIT), .SETTLE_CYC(50), .RELEASE_CYC(REL),
    .SELF_CYC(SELF)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .power_down_n(pd_n), .supply_ok(sup_ok),
    .ramp_reverse_switch_a(sw_a), .ramp_reverse_switch_b(sw_b),
    .ramp_rising(rising), .flag_release_n(rel_n),
    .charge_unit_flag_n_o(flag_o), .charge_unit_flag_n_oe(flag_oe),
    .charge_direction_o(dir_o), .charge_direction_oe(dir_oe),
    .low_power(low_power), .counts_settled(settled));
  ccfl_mcu_model #(.HOLD(REL + 6)) i_mcu (
    .sys_clk(sys_clk), .enable(mcu_en), .flag_pin_n(flag_pin_n),
    .dir_pin(dir_pin), .release_n(mcu_rel_n), .dir_seen(dir_seen));

  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : cmp_bit

  // Equal switches make polarity independent of ramp direction; mixed
  // switches make the wanted polarity depend on the coming ramp direction
  task automatic step(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      sw_a = mix ? (up ~^ rising) : up;
      sw_b = mix ? ~(up ~^ rising) : up;
      repeat (3) @(negedge sys_clk);
      rising = ~rising;
      repeat (7) @(negedge sys_clk);
    end
  endtask : step

  task automatic service();
    mcu_en = 1'b1;
    for (int i = 0; i < 40 && flag_oe !== 1'b0; i++) @(negedge sys_clk);
    mcu_en = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp_bit(flag_oe, 1'b0, "flag not released");
  endtask : service

  task automatic pd_test(input logic uv);
    step(1, 1'b1);
    step(3, 1'b0);
    if (uv)
      sup_ok = 1'b0;
    else
      pd_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    cmp_bit(flag_oe, 1'b0, "flag driven in power-down");
    cmp_bit(dir_oe, 1'b0, "direction driven");
    cmp_bit(low_power, !uv, "low power mode");
    pd_n   = 1'b1;
    sup_ok = 1'b1;
    // This reversal falls inside the init interval and must not count
    step(1, 1'b0);
    repeat (INIT) @(negedge sys_clk);
    cmp_bit(flag_oe, 1'b0, "flag survived reset");
    step(1, 1'b0);
    cmp_bit(flag_oe, 1'b1, "count survived reset");
    service();
  endtask : pd_test

  task automatic conclude();
    $display("Checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    #400_000;
    err_count++;
    conclude();
  end

  initial begin
    int seen;
    nrst     = 1'b0;
    pd_n     = 1'b1;
    sup_ok   = 1'b1;
    sw_a     = 1'b0;
    sw_b     = 1'b0;
    mix      = 1'b0;
    rising   = 1'b0;
    tb_rel_n = 1'b1;
    tied     = 1'b0;
    mcu_en   = 1'b0;
    repeat (10) @(negedge sys_clk);
    cmp_bit(flag_oe, 1'b0, "flag driven in reset");
    cmp_bit(dir_oe, 1'b0, "direction driven in reset");
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp_bit(low_power, 1'b0, "false power-down after reset");
    repeat (INIT + 4) @(negedge sys_clk);
    cmp_bit(settled, 1'b0, "settled too early");
    foreach (rows[i]) begin
      mix = rows[i].mix;
      step(rows[i].n, rows[i].up);
      cmp_bit(flag_oe, rows[i].flag, "unit flag");
      cmp_bit(flag_pin_n, !rows[i].flag, "unit flag pin");
      cmp_bit(dir_oe, rows[i].dir, "direction");
      cmp_bit(dir_pin, !rows[i].dir, "direction pin");
      if (rows[i].flag) begin
        service();
        cmp_bit(dir_seen, !rows[i].dir, "captured direction");
      end
    end
    mix = 1'b0;
    cmp_bit(settled, 1'b1, "counts not settled");
    step(1, 1'b1);
    step(1, 1'b0);
    cmp_bit(dir_oe, 1'b0, "direction not frozen");
    tb_rel_n = 1'b0;
    @(negedge sys_clk);
    tb_rel_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    cmp_bit(flag_oe, 1'b1, "glitch released flag");
    service();
    cmp_bit(dir_oe, 1'b1, "direction not live");
    repeat (10) @(negedge sys_clk);
    cmp_bit(flag_oe, 1'b0, "lost wrap flagged");
    pd_test(1'b0);
    pd_test(1'b1);
    tied = 1'b1;
    sw_a = 1'b1;
    sw_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    rising = ~rising;
    seen   = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (flag_oe === 1'b1)
        seen++;
    end
    cmp_bit(seen >= SELF, 1'b1, "tied flag too short");
    cmp_bit(flag_oe, 1'b0, "tied flag stuck");
    conclude();
  end
endmodule : tb_charge_count_flag_logic
